// [txlen_trim_defines.svh]
// Register offsets, field positions and reset values for the transmit length and antenna trim bank
`ifndef TXLEN_TRIM_DEFINES_SVH
`define TXLEN_TRIM_DEFINES_SVH

// Printed offsets are register indices; byte address is four times the index
`define IDX_TX_COUNT_LOW      8'h0b
`define IDX_TX_COUNT_HIGH     8'h0c
`define IDX_ADC_RESULT        8'h0d
`define IDX_ANT_CAL_RESULT    8'h0e
`define IDX_ANT_TRIM_OVR      8'h0f

// Field positions in the first count register
`define CNT_LOW_MSB           7
`define CNT_LOW_LSB           6
`define SPLIT_MSB             5
`define SPLIT_LSB             3
`define SHORT_RESP_BIT        1
`define ANTICOLL_BIT          0

// Field positions in the calibration and trim registers
`define CAL_TRIM_MSB          7
`define CAL_TRIM_LSB          4
`define CAL_ERR_BIT           3
`define TRIM_SRC_BIT          7
`define OVR_TRIM_MSB          6
`define OVR_TRIM_LSB          3

// Reset value and the split code for a whole final byte
`define RST_BYTE              8'h00
`define SPLIT_FULL_BYTE       3'h0

`endif

// [txlen_trim_pkg.sv]
// Types shared by the transmit length and antenna trim bank
package txlen_trim_pkg;

  typedef enum logic [2:0] {
    FRAME_IDLE = 3'b001,
    FRAME_TX   = 3'b010,
    FRAME_DONE = 3'b100
  } frame_state_t;

endpackage : txlen_trim_pkg

// [txlen_trim_regs.sv]
// APB register bank: transmit byte count, frame flags, A/D result and antenna LC trim
//
// Overview of operation
// - Ten-bit transmit count: low two bits at 0Bh[7:6], upper eight at 0Ch.
// - Split-byte field 0Bh[5:3] gives valid bits of final byte; zero means full.
// - Split-byte count applies only to anticollision frames with partial last byte.
// - Short-response and anticollision flags clear automatically when transmission completes.
// - Both count registers reset to zero on power-up, set-default and clear.
// - Read-only register shows latest 8-bit A/D result, bit 7 most significant.
// - A/D and calibration registers zero on power-up and set-default.
// - Calibration register holds 4-bit trim result in bits 7:4, MSB first.
// - Calibration error flag bit 3 set when resonance could not be reached.
// - Trim-source bit 7: zero picks calibration result, one picks software trim.
// - Software trim value in bits 6:3 drives switches only with source one.
// - Each set trim bit switches on that transistor in both pin groups.
`timescale 1ns/100ps
`include "txlen_trim_defines.svh"

module txlen_trim_regs
  import txlen_trim_pkg::*;
#(
  parameter int TRIM_W = 4
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Chip commands
  input  wire logic              set_default_i,
  input  wire logic              clear_cmd_i,
  // Framing engine
  input  wire logic              tx_start_i,
  input  wire logic              tx_done_i,
  output logic      [9:0]        tx_byte_count_o,
  output logic      [2:0]        split_bits_o,
  output logic                   short_response_flag_o,
  output logic                   anticoll_frame_o,
  // A/D converter
  input  wire logic              adc_valid_i,
  input  wire logic [7:0]        adc_data_i,
  // Calibration sequencer
  input  wire logic              cal_done_i,
  input  wire logic [TRIM_W-1:0] cal_trim_i,
  input  wire logic              cal_fail_i,
  // Trim switches
  output logic      [TRIM_W-1:0] trim_pins_group_one_o,
  output logic      [TRIM_W-1:0] trim_pins_group_two_o
);

  // Refuse trim widths that the register fields cannot carry
  if (TRIM_W != 4) begin : g_trim_w_check
    $error("TRIM_W must be 4");
  end
  if (`CAL_TRIM_MSB - `CAL_TRIM_LSB + 1 != TRIM_W) begin : g_cal_field_check
    $error("calibration trim field does not match TRIM_W");
  end
  if (`OVR_TRIM_MSB - `OVR_TRIM_LSB + 1 != TRIM_W) begin : g_ovr_field_check
    $error("software trim field does not match TRIM_W");
  end

  logic [7:0]         cnt_lo_q, cnt_lo_d;
  logic [7:0]         cnt_hi_q, cnt_hi_d;
  logic [7:0]         adc_q, adc_d;
  logic [7:0]         cal_q, cal_d;
  logic [7:0]         ovr_q, ovr_d;
  logic [31:0]        rdata_q, rdata_d;
  logic               ready_q, ready_d;
  logic               err_q, err_d;
  logic [TRIM_W-1:0]  trim_q, trim_d;
  logic [9:0]         txcnt_q, txcnt_d;
  logic [2:0]         split_q, split_d;
  logic               sresp_q, sresp_d;
  logic               acoll_q, acoll_d;
  frame_state_t       fs_q, fs_d;

  logic               acc;
  logic               wr;
  logic [9:0]         idx;
  logic               aligned;
  logic [7:0]         wbyte;

  assign acc     = psel_i & penable_i & ~ready_q;
  assign wr      = acc & pwrite_i & pstrb_i[0];
  assign idx     = paddr_i[11:2];
  assign aligned = (paddr_i[1:0] == 2'h0);
  assign wbyte   = pwdata_i[7:0];

  // Frame tracker: flags clear when a started transmission completes
  // A done pulse with no transmission under way is ignored
  always_comb begin
    fs_d = fs_q;
    case (fs_q)
      FRAME_IDLE: if (tx_start_i) fs_d = FRAME_TX;
      FRAME_TX:   if (tx_done_i) fs_d = FRAME_DONE;
      FRAME_DONE: fs_d = FRAME_IDLE;
      default:    fs_d = FRAME_IDLE;
    endcase
  end

  // Register bank next state
  // Later assignments win: writes, then the post-transmit clear, then captures, then commands
  always_comb begin
    cnt_lo_d = cnt_lo_q;
    cnt_hi_d = cnt_hi_q;
    adc_d    = adc_q;
    cal_d    = cal_q;
    ovr_d    = ovr_q;
    if (wr && aligned && idx == 10'(`IDX_TX_COUNT_LOW)) begin
      cnt_lo_d = wbyte & 8'hfb;
    end else if (wr && aligned && idx == 10'(`IDX_TX_COUNT_HIGH)) begin
      cnt_hi_d = wbyte;
    end else if (wr && aligned && idx == 10'(`IDX_ANT_TRIM_OVR)) begin
      ovr_d = wbyte & 8'hf8;
    end
    // A write landing in the clearing cycle loses its flag bits
    if (fs_q == FRAME_DONE) begin
      cnt_lo_d[`SHORT_RESP_BIT] = 1'b0;
      cnt_lo_d[`ANTICOLL_BIT]   = 1'b0;
    end
    if (adc_valid_i) begin
      adc_d = adc_data_i;
    end
    if (cal_done_i) begin
      cal_d = {cal_trim_i, cal_fail_i, 3'h0};
    end
    if (set_default_i || clear_cmd_i) begin
      cnt_lo_d = `RST_BYTE;
      cnt_hi_d = `RST_BYTE;
    end
    // Set-default also returns the software trim to its zero default
    if (set_default_i) begin
      adc_d = `RST_BYTE;
      cal_d = `RST_BYTE;
      ovr_d = `RST_BYTE;
    end
  end

  // APB answer one cycle into the access phase; error on unmapped or unaligned address
  // ready_q blocks a second take while the master still holds the access phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    ready_d = acc;
    err_d   = 1'b0;
    if (acc) begin
      if (!aligned) begin
        err_d = 1'b1;
      end else if (idx == 10'(`IDX_TX_COUNT_LOW)) begin
        rdata_d = {24'h00_0000, cnt_lo_q};
      end else if (idx == 10'(`IDX_TX_COUNT_HIGH)) begin
        rdata_d = {24'h00_0000, cnt_hi_q};
      end else if (idx == 10'(`IDX_ADC_RESULT)) begin
        rdata_d = {24'h00_0000, adc_q};
      end else if (idx == 10'(`IDX_ANT_CAL_RESULT)) begin
        rdata_d = {24'h00_0000, cal_q};
      end else if (idx == 10'(`IDX_ANT_TRIM_OVR)) begin
        rdata_d = {24'h00_0000, ovr_q};
      end else begin
        err_d = 1'b1;
      end
    end
  end

  // Outputs to framing engine and trim switches
  // Outside anticollision frames the framing engine sees a whole final byte
  always_comb begin
    txcnt_d = {cnt_hi_q, cnt_lo_q[`CNT_LOW_MSB:`CNT_LOW_LSB]};
    sresp_d = cnt_lo_q[`SHORT_RESP_BIT];
    acoll_d = cnt_lo_q[`ANTICOLL_BIT];
    if (cnt_lo_q[`ANTICOLL_BIT]) begin
      split_d = cnt_lo_q[`SPLIT_MSB:`SPLIT_LSB];
    end else begin
      split_d = `SPLIT_FULL_BYTE;
    end
    if (ovr_q[`TRIM_SRC_BIT]) begin
      trim_d = ovr_q[`OVR_TRIM_MSB:`OVR_TRIM_LSB];
    end else begin
      trim_d = cal_q[`CAL_TRIM_MSB:`CAL_TRIM_LSB];
    end
  end

  // All state and every output register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_lo_q <= `RST_BYTE;
      cnt_hi_q <= `RST_BYTE;
      adc_q    <= `RST_BYTE;
      cal_q    <= `RST_BYTE;
      ovr_q    <= `RST_BYTE;
      rdata_q  <= 32'h0000_0000;
      ready_q  <= 1'b0;
      err_q    <= 1'b0;
      txcnt_q  <= 10'h000;
      split_q  <= 3'h0;
      sresp_q  <= 1'b0;
      acoll_q  <= 1'b0;
      trim_q   <= '0;
      fs_q     <= FRAME_IDLE;
    end else begin
      cnt_lo_q <= cnt_lo_d;
      cnt_hi_q <= cnt_hi_d;
      adc_q    <= adc_d;
      cal_q    <= cal_d;
      ovr_q    <= ovr_d;
      rdata_q  <= rdata_d;
      ready_q  <= ready_d;
      err_q    <= err_d;
      txcnt_q  <= txcnt_d;
      split_q  <= split_d;
      sresp_q  <= sresp_d;
      acoll_q  <= acoll_d;
      trim_q   <= trim_d;
      fs_q     <= fs_d;
    end
  end

  // Both pin groups carry the same selected trim word
  assign trim_pins_group_one_o = trim_q;
  assign trim_pins_group_two_o = trim_q;
  assign tx_byte_count_o       = txcnt_q;
  assign split_bits_o          = split_q;
  assign short_response_flag_o = sresp_q;
  assign anticoll_frame_o      = acoll_q;
  assign prdata_o              = rdata_q;
  assign pready_o              = ready_q;
  assign pslverr_o             = err_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Output and register checks, sampled on the core clock
  count_join_a: assert property (tx_byte_count_o == {$past(cnt_hi_q), $past(cnt_lo_q[7:6])})
    else $error("transmit count does not join the two registers");
  split_gate_a: assert property (!cnt_lo_q[0] |=> split_bits_o == 3'h0)
    else $error("split count passed outside anticollision frame");
  split_pass_a: assert property (cnt_lo_q[0] |=> split_bits_o == $past(cnt_lo_q[5:3]))
    else $error("split count not passed in anticollision frame");
  flag_clear_a: assert property (fs_q == FRAME_DONE |=> cnt_lo_q[1:0] == 2'h0)
    else $error("frame flags not cleared after transmission");
  count_reset_a: assert property (clear_cmd_i |=> cnt_lo_q == 8'h00 && cnt_hi_q == 8'h00)
    else $error("count registers not cleared by command");
  adc_default_a: assert property (set_default_i |=> adc_q == 8'h00 && cal_q == 8'h00)
    else $error("result registers not zeroed by set-default");
  adc_capture_a: assert property (adc_valid_i && !set_default_i |=> adc_q == $past(adc_data_i))
    else $error("A/D result not captured");
  cal_capture_a: assert property (cal_done_i && !set_default_i |=>
    cal_q == {$past(cal_trim_i), $past(cal_fail_i), 3'h0})
    else $error("calibration result or error flag not captured");
  trim_sel_a: assert property (ovr_q[7] |=> trim_pins_group_one_o == $past(ovr_q[6:3]))
    else $error("software trim not driving switches");
  trim_cal_a: assert property (!ovr_q[7] |=> trim_pins_group_two_o == $past(cal_q[7:4]))
    else $error("calibration trim not driving switches");
  unused_zero_a: assert property (cnt_lo_q[2] == 1'b0 && ovr_q[2:0] == 3'h0)
    else $error("unused bit holds a value");

  // Register writes, read-only protection, read data and pin fan-out
  hi_write_a: assert property (wr && aligned && idx == 10'(`IDX_TX_COUNT_HIGH) &&
    !set_default_i && !clear_cmd_i |=> cnt_hi_q == $past(wbyte))
    else $error("upper count byte not written");
  lo_write_a: assert property (wr && aligned && idx == 10'(`IDX_TX_COUNT_LOW) &&
    fs_q != FRAME_DONE && !set_default_i && !clear_cmd_i |=> cnt_lo_q == ($past(wbyte) & 8'hfb))
    else $error("first count register not written with its unused bit masked");
  ovr_write_a: assert property (wr && aligned && idx == 10'(`IDX_ANT_TRIM_OVR) &&
    !set_default_i |=> ovr_q == ($past(wbyte) & 8'hf8))
    else $error("trim override register not written");
  adc_ro_a: assert property (wr && idx == 10'(`IDX_ADC_RESULT) &&
    !adc_valid_i && !set_default_i |=> adc_q == $past(adc_q))
    else $error("software write reached the A/D result");
  cal_ro_a: assert property (wr && idx == 10'(`IDX_ANT_CAL_RESULT) &&
    !cal_done_i && !set_default_i |=> cal_q == $past(cal_q))
    else $error("software write reached the calibration result");
  cal_err_a: assert property (cal_done_i && cal_fail_i && !set_default_i |=> cal_q[`CAL_ERR_BIT])
    else $error("calibration error flag not set");
  pins_equal_a: assert property (trim_pins_group_one_o == trim_pins_group_two_o)
    else $error("trim pin groups differ");
  flags_out_a: assert property ({short_response_flag_o, anticoll_frame_o} == $past(cnt_lo_q[1:0]))
    else $error("frame flag outputs do not follow the register");
  count_default_a: assert property (set_default_i |=> cnt_lo_q == 8'h00 && cnt_hi_q == 8'h00)
    else $error("count registers not zeroed by set-default");
  read_high_a: assert property (pready_o |-> prdata_o[31:8] == 24'h00_0000)
    else $error("read data carries bits above the register");
  refused_read_a: assert property (pslverr_o |-> prdata_o == 32'h0000_0000)
    else $error("refused access returned data");

  // Main scenarios the bench is expected to reach
  wr_cov_c:   cover property (wr ##1 pready_o);
  tx_cov_c:   cover property (fs_q == FRAME_TX ##[1:20] fs_q == FRAME_DONE);
  ovr_cov_c:  cover property (ovr_q[7] && trim_pins_group_one_o != 4'h0);
  err_cov_c:  cover property (pslverr_o);
  flag_cov_c: cover property (fs_q == FRAME_DONE && cnt_lo_q[1:0] != 2'h0);

endmodule : txlen_trim_regs

// [test_tx_length_and_antenna_trim_regs.sv]
// Self-checking testbench for the transmit length and antenna trim register bank
`timescale 1ns/100ps
module test_tx_length_and_antenna_trim_regs;
  import txlen_trim_pkg::*;
  logic        clk, rst, psel, pen, pwr, setd, clr, txs, txd, adv, cald, calf, pready, perr, sflag, aflag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, caltrim, pin1, pin2, t;
  logic [9:0]  cnt;
  logic [2:0]  split;
  logic [7:0]  adat, b0, b1, w;
  logic        er;
  int          bad_count, cmp_count, cyc;

  txlen_trim_regs #(.TRIM_W(4)) dut (
    .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .set_default_i(setd), .clear_cmd_i(clr), .tx_start_i(txs), .tx_done_i(txd), .tx_byte_count_o(cnt),
    .split_bits_o(split), .short_response_flag_o(sflag), .anticoll_frame_o(aflag), .adc_valid_i(adv),
    .adc_data_i(adat), .cal_done_i(cald), .cal_trim_i(caltrim), .cal_fail_i(calf),
    .trim_pins_group_one_o(pin1), .trim_pins_group_two_o(pin2));

  always #25 clk = ~clk;

  task automatic wrap_up;
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready without assuming latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, {idx[5:0], 6'h00} >> 4, 8'h00);
    chk(rd, {24'h00_0000, exp}, "read data");
    chk(32'(er), 32'h0000_0000, "read error");
  endtask : rdchk

  task automatic strobe(input logic [5:0] m);
    @(posedge clk);
    {setd, clr, txs, txd, adv, cald} <= m;
    @(posedge clk);
    {setd, clr, txs, txd, adv, cald} <= 6'h00;
  endtask : strobe

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic [2:0] exp_split(input logic [7:0] r);
    return r[0] ? r[5:3] : 3'h0;
  endfunction : exp_split

  task automatic pins(input logic [3:0] e);
    chk(32'(pin1), 32'(e), "trim group one");
    chk(32'(pin2), 32'(e), "trim group two");
  endtask : pins

  initial begin
    {clk, psel, pen, pwr, setd, clr, txs, txd, adv, cald, calf} = '0;
    rst = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    adat = 8'h00;
    caltrim = 4'h0;
    void'($urandom(39));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 11; i < 16; i++) rdchk(8'(i), 8'h00);
    for (int k = 0; k < 6; k++) begin
      b0 = (k == 0) ? 8'hff : (k == 1) ? 8'h3a : 8'($urandom);
      b1 = (k == 0) ? 8'hff : 8'($urandom);
      apb(1'b1, 12'h02c, b0);
      apb(1'b1, 12'h030, b1);
      settle();
      chk(32'(cnt), 32'({b1, b0[7:6]}), "byte count");
      chk(32'(split), 32'(exp_split(b0)), "split bits");
      chk(32'({sflag, aflag}), 32'(b0[1:0]), "frame flags");
      rdchk(8'h0b, b0 & 8'hfb);
      rdchk(8'h0c, b1);
      strobe(6'h08);
      strobe(6'h04);
      settle();
      chk(32'({sflag, aflag}), 32'h0000_0000, "flags after tx");
      chk(32'(cnt), 32'({b1, b0[7:6]}), "count after tx");
      rdchk(8'h0b, b0 & 8'hf8);
      adat <= 8'($urandom);
      strobe(6'h02);
      apb(1'b1, 12'h034, ~adat);
      rdchk(8'h0d, adat);
      t = 4'($urandom);
      caltrim <= t;
      calf <= k[0];
      strobe(6'h01);
      apb(1'b1, 12'h038, 8'hff);
      settle();
      rdchk(8'h0e, {t, k[0], 3'h0});
      pins(t);
      w = 8'($urandom) | 8'h80;
      apb(1'b1, 12'h03c, w);
      settle();
      pins(w[6:3]);
      rdchk(8'h0f, w & 8'hf8);
      apb(1'b1, 12'h03c, w & 8'h7f);
      settle();
      pins(t);
    end
    apb(1'b0, 12'h040, 8'h00);
    chk(32'(er), 32'h0000_0001, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped read data");
    apb(1'b0, 12'h02d, 8'h00);
    chk(32'(er), 32'h0000_0001, "unaligned error");
    chk(rd, 32'h0000_0000, "unaligned read data");
    apb(1'b1, 12'h02c, 8'hff);
    apb(1'b1, 12'h030, 8'ha5);
    apb(1'b1, 12'h03c, 8'hc8);
    strobe(6'h10);
    settle();
    rdchk(8'h0b, 8'h00);
    rdchk(8'h0c, 8'h00);
    rdchk(8'h0f, 8'hc8);
    strobe(6'h20);
    settle();
    for (int i = 11; i < 16; i++) rdchk(8'(i), 8'h00);
    pins(4'h0);
    wrap_up();
  end
endmodule : test_tx_length_and_antenna_trim_regs
